/* File: rtl/fcim_core.sv */
/*
 Interrupt gathering and masking unit of a four-channel bus I/O board,
 with its eight-port host register block and wait-state insertion.
 Assumes host strobes and address are synchronous to clk and held
 until the access ends; switches, jumpers, printer acknowledge and
 parallel strobe are asynchronous pins.
*/
`timescale 1ns/10ps
`include "fcim_map.svh"

// How it works
// - Jumpers add zero to three channel waits
// - Eight requests: transmit and receive per channel
// - Printer acknowledge raises channel zero transmit
// - Input strobe raises channel zero receive
// - Transmit request while holding register free
// - Receive request while unread character held
// - Each request gated by its mask bit
// - Open-collector active-low request outputs
// - Serial third condition: empty or modem change
// - Jumper merges third condition into request
// - Reset clears every mask bit
// - Mask writes only when group selected
// - One write updates masks of paired boards
// - Lower board uses data bits 0-3
// - Upper board uses data bits 4-7
// - Transmit mask port 4, receive port 5
// - Status reads own nibble, others float high
// - No waits on select or interrupt ports
// - Port 7 holds five-bit user number
module fcim_core
    import fcim_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host port bus
    input wire logic [7:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_data_in,
    output logic [7:0] io_data_out,
    output logic [7:0] io_data_oe_n,
    output logic bus_ready,
    // Board switches and jumpers
    input wire logic [4:0] base_addr_sw,
    input wire logic port_disable_sw,
    input wire logic group_select_low,
    input wire logic group_select_high,
    input wire logic group_half_select,
    input wire logic one_wait_jumper,
    input wire logic two_wait_jumper,
    input wire logic three_wait_jumper,
    input wire logic [3:1] merge_tx_jumper,
    input wire logic [3:1] merge_rx_jumper,
    // Channel conditions
    input wire logic [3:1] tx_holding_free,
    input wire logic [3:1] rx_char_available,
    input wire logic [3:1] tx_empty_or_modem_change,
    input wire logic printer_ack,
    input wire logic par_input_strobe,
    // Open-collector request lines
    output logic [3:0] tx_request_line_out,
    output logic [3:0] tx_request_line_oe_n,
    output logic [3:0] rx_request_line_out,
    output logic [3:0] rx_request_line_oe_n
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [19:0] pins_s;
    logic [4:0] base_s;
    logic [1:0] group_s;
    logic [2:0] jmp_s;
    logic [3:1] mtx_s, mrx_s;
    logic dis_s, half_s, ack_s, stb_s, ack_d, stb_d, ack_rise, stb_rise;

    fcim_sync #(.WIDTH(20)) u_sync (
        .clk(clk), .sys_rst(sys_rst),
        .async_in({base_addr_sw, port_disable_sw, group_select_high,
                   group_select_low, group_half_select, three_wait_jumper,
                   two_wait_jumper, one_wait_jumper, merge_tx_jumper,
                   merge_rx_jumper, printer_ack, par_input_strobe}),
        .sync_out(pins_s)
    );

    assign {base_s, dis_s, group_s, half_s, jmp_s, mtx_s, mrx_s,
            ack_s, stb_s} = pins_s;
    assign ack_rise = ack_s & ~ack_d;
    assign stb_rise = stb_s & ~stb_d;

    // ------------------------------------------------------------
    // Decode and request sources
    // ------------------------------------------------------------
    fcim_state_t state, next_state;
    logic [1:0] wait_cnt, next_wait_cnt, waits;
    logic [3:0] tx_mask, next_tx_mask, rx_mask, next_rx_mask;
    logic [4:0] user, next_user;
    logic ack_pend, next_ack_pend, stb_pend, next_stb_pend, next_ready;
    logic [7:0] next_data_out, next_data_oe_n;
    logic hit, access, in_group, board_sel, chan_port;
    logic [2:0] port;
    logic [3:0] nib, tx_pend, rx_pend;

    // Largest fitted jumper wins if several are fitted by mistake
    assign waits = jmp_s[2] ? `FCIM_WAIT_THREE
                 : jmp_s[1] ? `FCIM_WAIT_TWO
                 : jmp_s[0] ? `FCIM_WAIT_ONE
                 : `FCIM_WAIT_NONE;

    assign port = io_addr[2:0];
    assign hit = (io_rd | io_wr) & (io_addr[7:3] == base_s) & ~dis_s;
    assign chan_port = port < `FCIM_CH_PORT_LIMIT;
    assign in_group = user[`FCIM_USER_MSB:3] == group_s;
    assign board_sel = in_group & (user[2] == half_s);
    // Each board keeps only its own nibble of a group-wide byte
    assign nib = half_s ? io_data_in[7:4] : io_data_in[3:0];

    // Channel zero is the parallel pair; 1..3 are serial channels
    assign tx_pend = {tx_holding_free
                      | (mtx_s & tx_empty_or_modem_change),
                      ack_pend};
    assign rx_pend = {rx_char_available
                      | (mrx_s & tx_empty_or_modem_change),
                      stb_pend};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_tx_mask = tx_mask;
        next_rx_mask = rx_mask;
        next_user = user;
        next_ack_pend = ack_pend;
        next_stb_pend = stb_pend;
        next_ready = bus_ready;
        next_data_out = io_data_out;
        next_data_oe_n = io_data_oe_n;
        access = 1'b0;
        case (state)
            FCIM_IDLE: begin
                next_ready = 1'b1;
                next_data_oe_n = `FCIM_NO_DRIVE;
                if (hit) begin
                    // Fast ports never stall the bus
                    if (chan_port && waits != `FCIM_WAIT_NONE) begin
                        next_state = FCIM_WAIT;
                        next_wait_cnt = waits;
                        next_ready = 1'b0;
                    end else begin
                        access = 1'b1;
                        next_state = FCIM_HOLD;
                    end
                end
            end
            FCIM_WAIT: begin
                if (wait_cnt == `FCIM_WAIT_ONE) begin
                    access = 1'b1;
                    next_ready = 1'b1;
                    next_state = FCIM_HOLD;
                end else begin
                    next_wait_cnt = wait_cnt - `FCIM_WAIT_ONE;
                end
            end
            FCIM_HOLD: begin
                if (!io_rd && !io_wr) begin
                    next_state = FCIM_IDLE;
                    next_data_oe_n = `FCIM_NO_DRIVE;
                end
            end
            default: begin
                next_state = FCIM_IDLE;
            end
        endcase
        if (access && io_wr) begin
            case (port)
                `FCIM_PORT_TX_ENABLE: begin
                    if (in_group) begin
                        next_tx_mask = nib;
                    end
                end
                `FCIM_PORT_RX_ENABLE: begin
                    if (in_group) begin
                        next_rx_mask = nib;
                    end
                end
                `FCIM_PORT_USER_SEL: begin
                    next_user = io_data_in[4:0];
                end
                `FCIM_PORT_CH_DATA: begin
                    // Loading the printer register clears the pending printer acknowledge
                    if (board_sel && user[1:0] == 2'h0) begin
                        next_ack_pend = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (access && io_rd) begin
            case (port)
                `FCIM_PORT_TX_ENABLE, `FCIM_PORT_RX_ENABLE: begin
                    if (in_group) begin
                        // Status ignores the masks; foreign nibble floats
                        next_data_out = (port == `FCIM_PORT_TX_ENABLE)
                                        ? {tx_pend, tx_pend}
                                        : {rx_pend, rx_pend};
                        next_data_oe_n = half_s ? `FCIM_HIGH_NIBBLE_DRIVE
                                                : `FCIM_LOW_NIBBLE_DRIVE;
                    end
                end
                `FCIM_PORT_PAR_DATA: begin
                    if (board_sel && user[1:0] == 2'h0) begin
                        next_stb_pend = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // A new edge beats a host clear in the same cycle
        if (ack_rise) begin
            next_ack_pend = 1'b1;
        end
        if (stb_rise) begin
            next_stb_pend = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= FCIM_IDLE;
            wait_cnt <= `FCIM_WAIT_NONE;
            tx_mask <= `FCIM_MASK_RESET;
            rx_mask <= `FCIM_MASK_RESET;
            user <= `FCIM_USER_RESET;
            ack_pend <= 1'b0;
            stb_pend <= 1'b0;
            ack_d <= 1'b0;
            stb_d <= 1'b0;
            bus_ready <= 1'b1;
            io_data_out <= 8'h00;
            io_data_oe_n <= `FCIM_NO_DRIVE;
            tx_request_line_out <= 4'h0;
            tx_request_line_oe_n <= 4'hF;
            rx_request_line_out <= 4'h0;
            rx_request_line_oe_n <= 4'hF;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            tx_mask <= next_tx_mask;
            rx_mask <= next_rx_mask;
            user <= next_user;
            ack_pend <= next_ack_pend;
            stb_pend <= next_stb_pend;
            ack_d <= ack_s;
            stb_d <= stb_s;
            bus_ready <= next_ready;
            io_data_out <= next_data_out;
            io_data_oe_n <= next_data_oe_n;
            // Open collector: only ever pulls low, never drives high
            tx_request_line_out <= 4'h0;
            rx_request_line_out <= 4'h0;
            tx_request_line_oe_n <= ~(tx_pend & tx_mask);
            rx_request_line_oe_n <= ~(rx_pend & rx_mask);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_three_waits;
        !bus_ready [*3] ##1 bus_ready;
    endsequence
    sequence s_slow_start;
        state == FCIM_IDLE && hit && chan_port && waits == `FCIM_WAIT_THREE;
    endsequence

    property p_three_waits;
        @(posedge clk) disable iff (sys_rst)
        s_slow_start |=> s_three_waits;
    endproperty
    a_three_waits: assert property (p_three_waits)
        else $error("three wait states not inserted");
    property p_no_jumper;
        @(posedge clk) disable iff (sys_rst)
        state == FCIM_IDLE && hit && waits == `FCIM_WAIT_NONE
            |=> bus_ready && state == FCIM_HOLD;
    endproperty
    a_no_jumper: assert property (p_no_jumper)
        else $error("wait inserted with no jumper");
    property p_fast_ports;
        @(posedge clk) disable iff (sys_rst)
        state == FCIM_IDLE && hit && !chan_port |=> bus_ready [*2];
    endproperty
    a_fast_ports: assert property (p_fast_ports)
        else $error("wait inserted on fast port");
    property p_reset_clears;
        @(posedge clk)
        sys_rst |=> tx_mask == `FCIM_MASK_RESET && rx_mask == `FCIM_MASK_RESET
            && tx_request_line_oe_n == 4'hF;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("masks not cleared by reset");
    property p_gated_request;
        @(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) |-> tx_request_line_oe_n ==
            ~($past(tx_pend) & $past(tx_mask))
            && rx_request_line_oe_n == ~($past(rx_pend) & $past(rx_mask));
    endproperty
    a_gated_request: assert property (p_gated_request)
        else $error("request line does not follow pending and mask");
    property p_foreign_group;
        @(posedge clk) disable iff (sys_rst)
        access && io_wr && port == `FCIM_PORT_TX_ENABLE && !in_group
            |=> $stable(tx_mask);
    endproperty
    a_foreign_group: assert property (p_foreign_group)
        else $error("mask written while group not selected");
    property p_nibble_take;
        @(posedge clk) disable iff (sys_rst)
        access && io_wr && port == `FCIM_PORT_RX_ENABLE && in_group
            |=> rx_mask == (half_s ? $past(io_data_in[7:4])
                                   : $past(io_data_in[3:0]));
    endproperty
    a_nibble_take: assert property (p_nibble_take)
        else $error("wrong nibble taken into mask");
    property p_status_read;
        @(posedge clk) disable iff (sys_rst)
        access && io_rd && port == `FCIM_PORT_TX_ENABLE && in_group
            |=> io_data_oe_n == (half_s ? `FCIM_HIGH_NIBBLE_DRIVE
                                        : `FCIM_LOW_NIBBLE_DRIVE)
            && io_data_out[3:0] == $past(tx_pend);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read drives wrong bits");
    property p_ack_raises;
        @(posedge clk) disable iff (sys_rst)
        ack_rise |=> tx_pend[0] ##1 tx_request_line_oe_n[0] == ~tx_mask[0];
    endproperty
    a_ack_raises: assert property (p_ack_raises)
        else $error("printer acknowledge lost");
    property p_strobe_raises;
        @(posedge clk) disable iff (sys_rst)
        stb_rise |=> rx_pend[0];
    endproperty
    a_strobe_raises: assert property (p_strobe_raises)
        else $error("input strobe lost");
    property p_user_select;
        @(posedge clk) disable iff (sys_rst)
        access && io_wr && port == `FCIM_PORT_USER_SEL
            |=> user == $past(io_data_in[4:0]);
    endproperty
    a_user_select: assert property (p_user_select)
        else $error("user select not stored");

endmodule : fcim_core

/* File: rtl/fcim_map.svh */
/*
 Register offsets, reset values and wait-state counts of the
 four-channel interrupt gathering and masking unit.
 Assumes an eight-port block decoded on host address bits 7..3.
*/
`ifndef FCIM_MAP_SVH
`define FCIM_MAP_SVH

// ------------------------------------------------------------
// Relative port offsets
// ------------------------------------------------------------
`define FCIM_PORT_CH_DATA 3'h0
`define FCIM_PORT_PAR_DATA 3'h2
`define FCIM_PORT_TX_ENABLE 3'h4
`define FCIM_PORT_RX_ENABLE 3'h5
`define FCIM_PORT_USER_SEL 3'h7
`define FCIM_CH_PORT_LIMIT 3'h4

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define FCIM_USER_MSB 4
`define FCIM_MASK_RESET 4'h0
`define FCIM_USER_RESET 5'h00
`define FCIM_LOW_NIBBLE_DRIVE 8'hF0
`define FCIM_HIGH_NIBBLE_DRIVE 8'h0F
`define FCIM_NO_DRIVE 8'hFF

// ------------------------------------------------------------
// Wait-state counts per fitted jumper
// ------------------------------------------------------------
`define FCIM_WAIT_NONE 2'h0
`define FCIM_WAIT_ONE 2'h1
`define FCIM_WAIT_TWO 2'h2
`define FCIM_WAIT_THREE 2'h3

`endif

/* File: rtl/fcim_pkg.sv */
/*
 Types shared by the interrupt masking unit.
 Assumes fcim_map.svh supplies all numeric constants.
*/
package fcim_pkg;

    // Bus access sequencer states
    typedef enum logic [1:0] {
        FCIM_IDLE,
        FCIM_WAIT,
        FCIM_HOLD
    } fcim_state_t;

endpackage : fcim_pkg

/* File: rtl/fcim_sync.sv */
/*
 Two flip-flop synchroniser for a bundle of unrelated levels.
 Assumes each bit is a slow level or a pulse longer than two clocks.
*/
`timescale 1ns/10ps
module fcim_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : fcim_sync

/* File: test/fcim_host_bus.sv */
/*
 Host processor model for the port bus of the interrupt masking unit.
 Assumes one board at base BASE and a pull-up on every data bit.
*/
`timescale 1ns/10ps
module fcim_host_bus #(
    parameter logic [4:0] BASE = 5'h02
) (
    // Clock
    input wire logic clk,
    // Bus driven by the host
    output logic [7:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_data_in,
    // Bus driven by the board
    input wire logic [7:0] io_data_out,
    input wire logic [7:0] io_data_oe_n,
    input wire logic bus_ready
);
    // ----------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------
    // Single board, so every board on the bus shares one wait count
    initial begin
        io_addr = 8'h00;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_data_in = 8'h00;
    end

    // Strobe held until ready is sampled high; -1 waits marks a hang
    task automatic cycle(input logic rd, input logic [2:0] port,
                         input logic [7:0] wdata, output logic [7:0] rdata,
                         output int waits);
        int n;
        n = 0;
        waits = 0;
        @(posedge clk);
        #1;
        io_addr = {BASE, port};
        io_data_in = wdata;
        io_rd = rd;
        io_wr = !rd;
        @(posedge clk);
        while (n < 16) begin
            @(posedge clk);
            n++;
            if (bus_ready === 1'b1) break;
            waits++;
        end
        if (n == 16) waits = -1;
        // Undriven bits float to the pull-up
        rdata = io_data_out | io_data_oe_n;
        #1;
        io_rd = 1'b0;
        io_wr = 1'b0;
        // Released lines show junk, not the last value
        io_addr = ~io_addr;
        io_data_in = ~io_data_in;
    endtask : cycle
endmodule : fcim_host_bus

/* File: test/testbench.sv */
/*
 Self-checking bench for the interrupt masking unit.
 Assumes the host model drives the port bus; request lines are pulled up.
*/
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------------------------
    // Board and surroundings
    // ----------------------------------------------------------
    localparam logic [4:0] BASE = 5'h02;
    localparam logic [2:0] JMP [5] = '{3'b000, 3'b001, 3'b010, 3'b100,
                                       3'b111};
    localparam int WT [5] = '{0, 1, 2, 3, 3};
    logic clk, sys_rst, io_rd, io_wr, bus_ready;
    logic [7:0] io_addr, io_data_in, io_data_out, io_data_oe_n;
    logic [4:0] base_addr_sw;
    logic port_disable_sw, group_select_low, group_select_high;
    logic group_half_select, printer_ack, par_input_strobe;
    logic one_wait_jumper, two_wait_jumper, three_wait_jumper;
    logic [3:1] merge_tx_jumper, merge_rx_jumper, tx_holding_free;
    logic [3:1] rx_char_available, tx_empty_or_modem_change;
    logic [3:0] tx_request_line_out, tx_request_line_oe_n, tx_wire;
    logic [3:0] rx_request_line_out, rx_request_line_oe_n, rx_wire;
    logic [7:0] rd;
    int w;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // Open-collector lines: low only where driven
    assign tx_wire = tx_request_line_out | tx_request_line_oe_n;
    assign rx_wire = rx_request_line_out | rx_request_line_oe_n;

    fcim_core dut (.clk, .sys_rst, .io_addr, .io_rd, .io_wr, .io_data_in,
        .io_data_out, .io_data_oe_n, .bus_ready, .base_addr_sw,
        .port_disable_sw, .group_select_low, .group_select_high,
        .group_half_select, .one_wait_jumper, .two_wait_jumper,
        .three_wait_jumper, .merge_tx_jumper, .merge_rx_jumper,
        .tx_holding_free, .rx_char_available, .tx_empty_or_modem_change,
        .printer_ack, .par_input_strobe, .tx_request_line_out,
        .tx_request_line_oe_n, .rx_request_line_out, .rx_request_line_oe_n);

    fcim_host_bus #(.BASE(BASE)) host (.clk, .io_addr, .io_rd, .io_wr,
        .io_data_in, .io_data_out, .io_data_oe_n, .bus_ready);

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : gap

    task automatic wr(input logic [2:0] port, input logic [7:0] d);
        logic [7:0] r;
        host.cycle(1'b0, port, d, r, w);
        gap(2);
    endtask : wr

    task automatic rdp(input logic [2:0] port);
        host.cycle(1'b1, port, 8'h00, rd, w);
        gap(1);
    endtask : rdp

    task automatic lines(input logic [3:0] et, input logic [3:0] er);
        check("tx lines", {4'h0, et}, {4'h0, tx_wire});
        check("rx lines", {4'h0, er}, {4'h0, rx_wire});
    endtask : lines

    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // A hang is cut short well beyond the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        base_addr_sw = BASE;
        port_disable_sw = 1'b0;
        group_select_low = 1'b0;
        group_select_high = 1'b1;
        group_half_select = 1'b0;
        {three_wait_jumper, two_wait_jumper, one_wait_jumper} = 3'b000;
        merge_tx_jumper = 3'b000;
        merge_rx_jumper = 3'b000;
        tx_holding_free = 3'b000;
        rx_char_available = 3'b000;
        tx_empty_or_modem_change = 3'b000;
        printer_ack = 1'b0;
        par_input_strobe = 1'b0;
        gap(5);
        sys_rst = 1'b0;
        gap(3);
        tx_holding_free = 3'b111;
        rx_char_available = 3'b111;
        gap(3);
        lines(4'hF, 4'hF);
        rdp(3'h4);
        check("status out of group", 8'hFF, rd);
        wr(3'h4, 8'hFF);
        lines(4'hF, 4'hF);
        wr(3'h7, 8'h10);
        rdp(3'h4);
        check("tx status", 8'hFE, rd);
        rdp(3'h5);
        check("rx status", 8'hFE, rd);
        wr(3'h4, 8'h5A);
        lines(4'h5, 4'hF);
        wr(3'h5, 8'hA5);
        lines(4'h5, 4'hB);
        wr(3'h4, 8'h0F);
        lines(4'h1, 4'hB);
        printer_ack = 1'b1;
        gap(4);
        printer_ack = 1'b0;
        gap(6);
        lines(4'h0, 4'hB);
        par_input_strobe = 1'b1;
        gap(4);
        par_input_strobe = 1'b0;
        gap(6);
        lines(4'h0, 4'hA);
        wr(3'h0, 8'h00);
        lines(4'h1, 4'hA);
        rdp(3'h2);
        gap(2);
        lines(4'h1, 4'hB);
        tx_holding_free = 3'b110;
        rx_char_available = 3'b101;
        gap(2);
        lines(4'h3, 4'hF);
        // A disabled block must ignore a mask write aimed at it
        port_disable_sw = 1'b1;
        gap(4);
        wr(3'h4, 8'h00);
        lines(4'h3, 4'hF);
        port_disable_sw = 1'b0;
        group_half_select = 1'b1;
        gap(4);
        wr(3'h4, 8'h5A);
        lines(4'hB, 4'hF);
        rdp(3'h4);
        check("tx status upper", 8'hCF, rd);
        rdp(3'h6);
        check("unused port", 8'hFF, rd);
        // Merged cause: software must read channel status to tell
        tx_holding_free = 3'b000;
        tx_empty_or_modem_change = 3'b010;
        gap(5);
        lines(4'hF, 4'hF);
        merge_tx_jumper = 3'b010;
        merge_rx_jumper = 3'b010;
        gap(5);
        lines(4'hB, 4'hB);
        for (int k = 0; k < 5; k++) begin
            {three_wait_jumper, two_wait_jumper, one_wait_jumper} = JMP[k];
            gap(5);
            rdp(3'h1);
            check("channel waits", 8'(WT[k]), w[7:0]);
            rdp(3'h4);
            check("status waits", 8'h00, w[7:0]);
            wr(3'h7, 8'h10);
            check("select waits", 8'h00, w[7:0]);
        end
        sys_rst = 1'b1;
        gap(3);
        sys_rst = 1'b0;
        gap(3);
        lines(4'hF, 4'hF);
        close_out();
    end
endmodule : testbench
